// ### run_mode_clock_config.v
// What this block does
// - auto gating set: sleep uses sleep gating, deep sleep uses deep-sleep gating
// - run mode always uses run gating enables
// - four-bit divisor divides pll or oscillator source; resets to all ones
// - pll in use and divisor below minimum: minimum divisor substituted
// - pll unused: programmed divisor applied even below minimum
// - divider enable picks divider; pll selection forces divider use
// - second config override set: second divisor replaces this divisor
// - power-down bit drives pll power-down directly; resets to one
// - bypass set selects oscillator source, clear selects divided pll; resets to one
// - reserved bits read zero except bit 12 reads one
// - oscillator select zero is main, one internal (reset)
`timescale 1ns/1ps
`default_nettype none
`include "run_clock_map.vh"

module run_mode_clock_config (
  input  wire        mclk,
  input  wire        reset,
  input  wire [7:0]  address,
  input  wire [31:0] writeData,
  input  wire        writeStrobe,
  input  wire        readStrobe,
  output reg  [31:0] readData,
  input  wire [1:0]  powerMode,
  input  wire [31:0] runGatingRegs,
  input  wire [31:0] sleepGatingRegs,
  input  wire [31:0] deepSleepGatingRegs,
  input  wire        muxIdle,
  output reg  [31:0] peripheralClockEnable,
  output reg         pllPowerDown,
  output reg         bypassSelect,
  output reg         dividerSelect,
  output reg  [3:0]  effectiveDivisor,
  output reg  [1:0]  oscillatorSelect,
  output reg  [3:0]  crystalValue,
  output reg         mainOscillatorSelect,
  output reg         updatePending
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg [31:0] runConfig;
  reg [31:0] secondConfig;

  function [31:0] merge;
    input [31:0] oldValue;
    input [31:0] newValue;
    input [31:0] mask;
    begin
      merge = (oldValue & ~mask) | (newValue & mask);
    end
  endfunction

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      runConfig    <= `RUN_RESET_VALUE;
      secondConfig <= `SECOND_RESET_VALUE;
    end
    else if (writeStrobe)
    begin
      if (address == `ADDR_RUN_CONFIG)
        runConfig <= merge(runConfig, writeData, `RUN_WRITE_MASK);
      if (address == `ADDR_SECOND_CONFIG)
        secondConfig <= merge(secondConfig, writeData, `SECOND_WRITE_MASK);
    end
  end

  // --------------------------------------------------------------------------
  // divisor and source selection
  // --------------------------------------------------------------------------
  wire [3:0] programmedDivisor = secondConfig[`BIT_SECOND_OVERRIDE] ?
                                 secondConfig[`DIV2_HI:`DIV2_LO] :
                                 runConfig[`DIV_HI:`DIV_LO];
  wire       pllInUse = ~runConfig[`BIT_BYPASS];
  wire [3:0] next_divisor = clamp_divisor(programmedDivisor, pllInUse);

  // minimum divisor only applies while the pll feeds the divider
  function [3:0] clamp_divisor;
    input [3:0] divisor;
    input       pllUsed;
    begin
      if (pllUsed && divisor < `MINIMUM_DIVISOR)
        clamp_divisor = `MINIMUM_DIVISOR;
      else
        clamp_divisor = divisor;
    end
  endfunction
  wire       next_divider = runConfig[`BIT_DIVIDER_ENABLE] | pllInUse;
  wire       changed = (next_divisor != effectiveDivisor) ||
                       (next_divider != dividerSelect) ||
                       (runConfig[`BIT_BYPASS] != bypassSelect) ||
                       (runConfig[`OSC_HI:`OSC_LO] != oscillatorSelect);

  // selections only move while the mux reports a safe point
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      effectiveDivisor     <= 4'hF;
      dividerSelect        <= 1'b0;
      bypassSelect         <= 1'b1;
      oscillatorSelect     <= `OSC_INTERNAL;
      mainOscillatorSelect <= 1'b0;
      updatePending        <= 1'b0;
    end
    else
    begin
      updatePending <= changed & ~muxIdle;
      if (changed && muxIdle)
      begin
        effectiveDivisor     <= next_divisor;
        dividerSelect        <= next_divider;
        bypassSelect         <= runConfig[`BIT_BYPASS];
        oscillatorSelect     <= runConfig[`OSC_HI:`OSC_LO];
        mainOscillatorSelect <= (runConfig[`OSC_HI:`OSC_LO] == `OSC_MAIN);
      end
    end
  end

  // --------------------------------------------------------------------------
  // pll control and gating
  // --------------------------------------------------------------------------
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pllPowerDown          <= 1'b1;
      crystalValue          <= 4'hB;
      peripheralClockEnable <= 32'h00000000;
    end
    else
    begin
      pllPowerDown <= runConfig[`BIT_PLL_POWER_DOWN];
      crystalValue <= runConfig[`XTAL_HI:`XTAL_LO];
      if (powerMode == `MODE_RUN || !runConfig[`BIT_AUTO_GATING])
        peripheralClockEnable <= runGatingRegs;
      else if (powerMode == `MODE_SLEEP)
        peripheralClockEnable <= sleepGatingRegs;
      else
        peripheralClockEnable <= deepSleepGatingRegs;
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      readData <= 32'h00000000;
    else if (readStrobe)
    begin
      case (address)
        `ADDR_RUN_CONFIG:
          readData <= (runConfig & `RUN_READ_MASK) | `RUN_ONE_MASK;
        `ADDR_SECOND_CONFIG:
          readData <= secondConfig & `SECOND_WRITE_MASK;
        `ADDR_STATUS:
          readData <= {20'h00000, updatePending, dividerSelect, bypassSelect,
                       pllPowerDown, effectiveDivisor, oscillatorSelect, 2'h0};
        default:
          readData <= 32'h00000000;
      endcase
    end
    else
      readData <= 32'h00000000;
  end

endmodule // run_mode_clock_config
`default_nettype wire

// ### run_clock_map.vh
`ifndef RUN_CLOCK_MAP_VH
`define RUN_CLOCK_MAP_VH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define ADDR_RUN_CONFIG        8'h60
`define ADDR_SECOND_CONFIG     8'h70
`define ADDR_STATUS            8'h74

// ----------------------------------------------------------------------------
// run configuration fields
// ----------------------------------------------------------------------------
`define RUN_RESET_VALUE        32'h07803AD1
`define RUN_WRITE_MASK         32'h0FC02BF0
`define RUN_ONE_MASK           32'h00001000
`define RUN_READ_MASK          32'h0FC02BFF
`define BIT_AUTO_GATING        27
`define DIV_HI                 26
`define DIV_LO                 23
`define BIT_DIVIDER_ENABLE     22
`define BIT_PLL_POWER_DOWN     13
`define BIT_BYPASS             11
`define XTAL_HI                9
`define XTAL_LO                6
`define OSC_HI                 5
`define OSC_LO                 4

// ----------------------------------------------------------------------------
// second configuration fields
// ----------------------------------------------------------------------------
`define SECOND_RESET_VALUE     32'h07C00000
`define SECOND_WRITE_MASK      32'h87C00000
`define BIT_SECOND_OVERRIDE    31
`define DIV2_HI                26
`define DIV2_LO                23

// ----------------------------------------------------------------------------
// constants
// ----------------------------------------------------------------------------
`define MINIMUM_DIVISOR        4'h3
`define OSC_MAIN               2'h0
`define OSC_INTERNAL           2'h1
`define MODE_RUN               2'h0
`define MODE_SLEEP             2'h1
`define MODE_DEEP_SLEEP        2'h2

`endif

// ### run_clock_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "run_clock_map.vh"
module run_clock_monitor (
  input wire logic        mclk, reset, writeStrobe, readStrobe, muxIdle,
  input wire logic        pllPowerDown, bypassSelect, dividerSelect,
  input wire logic [7:0]  address,
  input wire logic [1:0]  powerMode,
  input wire logic [3:0]  effectiveDivisor,
  input wire logic [31:0] writeData, readData, runGatingRegs, sleepGatingRegs,
  input wire logic [31:0] deepSleepGatingRegs, peripheralClockEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic autoGate;
  wire  runWrite = writeStrobe && address == `ADDR_RUN_CONFIG;
  always_ff @(posedge mclk or posedge reset)
    if (reset) autoGate <= 1'b0;
    else if (runWrite) autoGate <= writeData[`BIT_AUTO_GATING];
  run_gating_a: assert property (powerMode == `MODE_RUN |=>
    peripheralClockEnable == $past(runGatingRegs)) else $error("run gating wrong");
  sleep_gating_a: assert property (powerMode == `MODE_SLEEP |=> peripheralClockEnable ==
    ($past(autoGate) ? $past(sleepGatingRegs) : $past(runGatingRegs))) else $error("sleep gating wrong");
  deep_gating_a: assert property (powerMode[1] |=> peripheralClockEnable ==
    ($past(autoGate) ? $past(deepSleepGatingRegs) : $past(runGatingRegs))) else $error("deep gating");
  pll_power_down_follow_a: assert property (runWrite ##1 1'b1 |=>
    pllPowerDown == $past(writeData[`BIT_PLL_POWER_DOWN], 2)) else $error("pll power-down wrong");
  reserved_bits_a: assert property (readStrobe && address == `ADDR_RUN_CONFIG |=>
    (readData & 32'hF03FC400) == 32'h0 && readData[12]) else $error("reserved bits wrong");
  mux_hold_a: assert property (!muxIdle |=> $stable(bypassSelect) &&
    $stable(effectiveDivisor) && $stable(dividerSelect)) else $error("mux moved while busy");
  pll_clamp_a: assert property (!bypassSelect |-> dividerSelect &&
    effectiveDivisor >= `MINIMUM_DIVISOR) else $error("pll divisor not clamped");
  bypass_apply_a: assert property (runWrite ##1 muxIdle |=>
    bypassSelect == $past(writeData[`BIT_BYPASS], 2)) else $error("bypass not applied");
endmodule // run_clock_monitor
bind run_mode_clock_config run_clock_monitor i_run_clock_monitor (.*);
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "run_clock_map.vh"
module tb;
  logic        mclk = 0, reset = 1, writeStrobe = 0, readStrobe = 0, muxIdle = 1;
  logic        holdIdle = 1, rdPend = 0, pllPd, mainOsc;
  logic [3:0]  xtal;
  logic [7:0]  address = 0;
  logic [1:0]  powerMode = 0;
  logic [31:0] writeData = 0, readData, runGate = 0, sleepGate = 0, deepGate = 0;
  logic [63:0] expQ[$];
  int          err_count = 0, comparisons = 0, cycles = 0;
  run_mode_clock_config i_run_mode_clock_config (.mclk(mclk), .reset(reset), .address(address),
    .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .powerMode(powerMode), .runGatingRegs(runGate),
    .sleepGatingRegs(sleepGate), .deepSleepGatingRegs(deepGate), .muxIdle(muxIdle),
    .peripheralClockEnable(), .pllPowerDown(pllPd), .bypassSelect(), .dividerSelect(),
    .effectiveDivisor(), .oscillatorSelect(), .crystalValue(xtal), .mainOscillatorSelect(mainOsc),
    .updatePending());
  initial forever #2.5 mclk = ~mclk;
  task automatic close_out;
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    {runGate, sleepGate, deepGate} <= {$urandom, $urandom, $urandom};
    powerMode <= 2'($urandom);
    muxIdle <= holdIdle | 1'($urandom);
    cycles <= cycles + 1;
    if (cycles > 5000)
    begin
      err_count++;
      close_out;
    end
  end
  // oldest expected read against the data of this cycle
  always @(posedge mclk)
  begin
    if (rdPend)
    begin
      comparisons++;
      if ((readData & expQ[0][31:0]) !== expQ[0][63:32])
      begin
        err_count++;
        $display("[FAIL] %0t read %h expected %h", $time, readData, expQ[0][63:32]);
      end
      void'(expQ.pop_front());
    end
    rdPend <= readStrobe;
  end
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic rd,
                     input logic [31:0] e, input logic [31:0] m);
    @(posedge mclk);
    {address, writeData, writeStrobe, readStrobe} <= {a, d, !rd, rd};
    if (rd) expQ.push_back({e & m, m});
    @(posedge mclk);
    {writeStrobe, readStrobe} <= 2'b00;
  endtask
  initial
  begin
    logic [3:0] d, d2, eff;
    logic       g, b, de, ov, os, p;
    void'($urandom(80643));
    repeat (16) @(posedge mclk);
    reset <= 0;
    acc(`ADDR_RUN_CONFIG, 0, 1, `RUN_RESET_VALUE, '1);
    acc(`ADDR_SECOND_CONFIG, 0, 1, `SECOND_RESET_VALUE, '1);
    acc(`ADDR_STATUS, 0, 1, 32'h000003F4, '1);
    acc(8'h10, '1, 0, 0, 0);
    acc(8'h10, 0, 1, 0, '1);
    acc(`ADDR_RUN_CONFIG, '1, 0, 0, 0);
    acc(`ADDR_RUN_CONFIG, 0, 1, 32'h0FC03BF1, '1);
    repeat (64)
    begin
      {d, d2, g, b, de, ov, os, p} = 14'($urandom);
      holdIdle <= 0;
      acc(`ADDR_SECOND_CONFIG, {ov, 4'h0, d2, 23'h0}, 0, 0, 0);
      acc(`ADDR_RUN_CONFIG, {4'h0, g, d, de, 8'h0, p, 1'b0, b, 6'h0, os, 4'h0}, 0, 0, 0);
      holdIdle <= 1;
      repeat (4) @(posedge mclk);
      comparisons++;
      if (pllPd !== p || mainOsc !== !os || xtal !== 4'h0)
      begin
        err_count++;
        $display("[FAIL] %0t pll power-down, oscillator or crystal output wrong", $time);
      end
      eff = ov ? d2 : d;
      if (!b && eff < `MINIMUM_DIVISOR) eff = `MINIMUM_DIVISOR;
      acc(`ADDR_STATUS, 0, 1, {21'h0, de | !b, b, p, eff, 1'b0, os, 2'b00},
          '1);
    end
    repeat (4) @(posedge mclk);
    close_out;
  end
endmodule // tb
`default_nettype wire
